//--- core/isp_target.sv
// target end: serial instruction decoder with memories, fuses and busy timer
`timescale 1ns/1ps
`include "isp_defs.svh"

// What this block does
// - busy eeprom location reads all ones
// - programmer waits after unpolled ones write
// - programmer waits minimum delays without polling
// - skip ones writes only after erase
// - four byte instructions, enable is ac 53
// - ac 80 erases flash and eeprom
// - poll returns busy in bit zero
// - 48 and 40 load page buffer
// - programmer loads low byte before high
// - 28 and 20 read flash bytes
// - other reads answer in fourth byte
// - 4c commits page buffer to flash
// - c0 c1 c2 handle eeprom writes
// - ac e0 writes lock, ac a0 a8 a4 write fuses
// - zero means programmed, one unprogrammed
// - programmer writes ones to unused fuses
// - 4d latches extended address byte
// - echo second byte during third byte
// - sample on rise, shift on fall
module isp_target import isp_pkg::*; #(
	parameter int unsigned FLASH_AW = 6,
	parameter int unsigned PAGE_AW = 3,
	parameter int unsigned EE_AW = 5,
	parameter int unsigned EE_PAGE_AW = 2,
	parameter byte_t LOCK_INIT = 8'hff,
	parameter byte_t FUSE_LO_INIT = 8'hff,
	parameter byte_t FUSE_HI_INIT = 8'hff,
	parameter byte_t FUSE_EXT_INIT = 8'hff,
	// signature and calibration values are arbitrary
	parameter byte_t SIG0 = 8'h11,
	parameter byte_t SIG1 = 8'h22,
	parameter byte_t SIG2 = 8'h33,
	parameter byte_t CALIB = 8'h80,
	parameter int unsigned FUSE_CYC =
		int'($ceil(`FUSE_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned PAGE_CYC =
		int'($ceil(`PAGE_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned EE_CYC =
		int'($ceil(`EEPROM_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned ERASE_CYC =
		int'($ceil(`ERASE_WAIT_MS * `REF_CLK_MHZ * 1000.0))
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	isp_link_if.target link,
	output logic busy_o,
	output logic prog_enabled_o
);
	localparam int unsigned FLASH_WORDS = 2 ** FLASH_AW;
	localparam int unsigned PAGE_WORDS = 2 ** PAGE_AW;
	localparam int unsigned EE_BYTES = 2 ** EE_AW;
	localparam int unsigned EE_PAGE = 2 ** EE_PAGE_AW;

	logic [1:0] sck_s, mosi_s, rstn_s;
	logic sck_d, rise, fall, in_prog;
	logic [4:0] bit_cnt;
	byte_t shreg, b1, b2, b3, b4, out_sh, rd_data, next_byte;
	byte_t ext_addr, lock, fuse_lo, fuse_hi, fuse_ext;
	logic exec_go, prog_en;
	logic [15:0] flash [FLASH_WORDS];
	logic [15:0] pbuf [PAGE_WORDS];
	byte_t eeprom [EE_BYTES];
	byte_t eebuf [EE_PAGE];
	logic [EE_PAGE-1:0] ee_valid;
	logic [31:0] busy_cnt;
	logic busy_flash, busy_ee, busy_ee_pg, ee_hit;
	logic [FLASH_AW-1:PAGE_AW] busy_page;
	logic [EE_AW-1:0] busy_ee_addr;
	logic [23:0] rd_addr, ex_addr;
	logic [FLASH_AW-1:0] rd_fa, ex_fa;
	logic [EE_AW-1:0] rd_ea, ex_ea;
	logic go, do_en, do_erase, do_lock, do_flo, do_fhi, do_fext;
	logic do_ext, do_ldhi, do_ldlo, do_page, do_eew, do_eel, do_eep;

	// two-flop synchronisers for the link pins, then edge detect on sck
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_s <= 2'b00;
			mosi_s <= 2'b00;
			rstn_s <= 2'b11;
			sck_d <= 1'b0;
		end else begin
			sck_s <= {sck_s[0], link.sck};
			mosi_s <= {mosi_s[0], link.mosi};
			rstn_s <= {rstn_s[0], link.prog_reset_n};
			sck_d <= sck_s[1];
		end
	end
	assign rise = sck_s[1] & ~sck_d;
	assign fall = ~sck_s[1] & sck_d;
	assign in_prog = ~rstn_s[1];
	assign next_byte = {shreg[6:0], mosi_s[1]};

	// input shifter and byte capture; counting restarts while reset is high
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt <= 5'h00;
			shreg <= `ZERO_BYTE;
			b1 <= `ZERO_BYTE;
			b2 <= `ZERO_BYTE;
			b3 <= `ZERO_BYTE;
			b4 <= `ZERO_BYTE;
			exec_go <= 1'b0;
		end else begin
			exec_go <= 1'b0;
			if (!in_prog) begin
				bit_cnt <= 5'h00;
			end else if (rise) begin
				shreg <= next_byte;
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == 5'd7) b1 <= next_byte;
				if (bit_cnt == 5'd15) b2 <= next_byte;
				if (bit_cnt == 5'd23) b3 <= next_byte;
				if (bit_cnt == 5'd31) begin
					b4 <= next_byte;
					exec_go <= 1'b1;
				end
			end
		end
	end

	// output shifter: first byte zero, echo after, result in the fourth byte
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_sh <= `ZERO_BYTE;
			link.miso <= 1'b0;
		end else if (!in_prog) begin
			out_sh <= `ZERO_BYTE;
			link.miso <= 1'b0;
		end else if (rise && bit_cnt[2:0] == 3'd7) begin
			if (bit_cnt == 5'd23) out_sh <= rd_data;
			else if (bit_cnt == 5'd31) out_sh <= `ZERO_BYTE;
			else out_sh <= next_byte;
		end else if (fall) begin
			link.miso <= out_sh[7];
			out_sh <= {out_sh[6:0], 1'b0};
		end
	end

	// read data, formed while the third byte completes
	assign rd_addr = {ext_addr, b2, next_byte};
	assign rd_fa = rd_addr[FLASH_AW-1:0];
	assign rd_ea = rd_addr[EE_AW-1:0];
	// a page commit marks its whole page busy, a byte write one location
	assign ee_hit = busy_ee_pg ?
		rd_ea[EE_AW-1:EE_PAGE_AW] == busy_ee_addr[EE_AW-1:EE_PAGE_AW] :
		rd_ea == busy_ee_addr;
	always_comb begin
		rd_data = `ZERO_BYTE;
		case (b1)
			`OP_READ_HI: rd_data = (busy_flash &&
				rd_fa[FLASH_AW-1:PAGE_AW] == busy_page) ?
				`ERASED_BYTE : flash[rd_fa][15:8];
			`OP_READ_LO: rd_data = (busy_flash &&
				rd_fa[FLASH_AW-1:PAGE_AW] == busy_page) ?
				`ERASED_BYTE : flash[rd_fa][7:0];
			`OP_EE_READ: rd_data = (busy_ee && ee_hit) ?
				`ERASED_BYTE : eeprom[rd_ea];
			`OP_READ_LOCK: rd_data = (b2 == `SUB_HI_SEL) ?
				fuse_hi : lock;
			`OP_READ_FUSE: rd_data = (b2 == `SUB_HI_SEL) ?
				fuse_ext : fuse_lo;
			`OP_SIG: begin
				case (next_byte[1:0])
					2'd0: rd_data = SIG0;
					2'd1: rd_data = SIG1;
					2'd2: rd_data = SIG2;
					default: rd_data = `ERASED_BYTE;
				endcase
			end
			`OP_CALIB: rd_data = CALIB;
			`OP_POLL: rd_data = {7'h00, busy_o};
			default: rd_data = `ZERO_BYTE;
		endcase
	end

	// decode of a complete instruction by its first byte, and by its second byte under the control opcode
	assign ex_addr = {ext_addr, b2, b3};
	assign ex_fa = ex_addr[FLASH_AW-1:0];
	assign ex_ea = ex_addr[EE_AW-1:0];
	assign go = exec_go & prog_en;
	assign do_en = exec_go && b1 == `OP_CTRL && b2 == `SUB_PROG_EN;
	assign do_erase = go && b1 == `OP_CTRL && b2 == `SUB_ERASE;
	assign do_lock = go && b1 == `OP_CTRL && b2 == `SUB_LOCK;
	assign do_flo = go && b1 == `OP_CTRL && b2 == `SUB_FUSE_LO;
	assign do_fhi = go && b1 == `OP_CTRL && b2 == `SUB_FUSE_HI;
	assign do_fext = go && b1 == `OP_CTRL && b2 == `SUB_FUSE_EXT;
	assign do_ext = go && b1 == `OP_EXT_ADDR;
	assign do_ldhi = go && b1 == `OP_LOAD_HI;
	assign do_ldlo = go && b1 == `OP_LOAD_LO;
	assign do_page = go && b1 == `OP_PAGE_WR;
	assign do_eew = go && b1 == `OP_EE_WRITE;
	assign do_eel = go && b1 == `OP_EE_LOAD;
	assign do_eep = go && b1 == `OP_EE_PAGE;

	// programming enable; dropped whenever reset is released
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) prog_en <= 1'b0;
		else if (!in_prog) prog_en <= 1'b0;
		else if (do_en) prog_en <= 1'b1;
	end
	assign prog_enabled_o = prog_en;

	// lock, fuses and extended address; stored as written, zero = programmed
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock <= LOCK_INIT;
			fuse_lo <= FUSE_LO_INIT;
			fuse_hi <= FUSE_HI_INIT;
			fuse_ext <= FUSE_EXT_INIT;
			ext_addr <= `ZERO_BYTE;
		end else begin
			if (do_erase) lock <= `ERASED_BYTE;
			else if (do_lock) lock <= b4;
			if (do_flo) fuse_lo <= b4;
			if (do_fhi) fuse_hi <= b4;
			if (do_fext) fuse_ext <= b4;
			if (do_ext) ext_addr <= b3;
		end
	end

	// flash and eeprom page buffers, flash words and eeprom bytes
	genvar g;
	generate
		for (g = 0; g < PAGE_WORDS; g++) begin : gen_pbuf
			localparam logic [PAGE_AW-1:0] PI = PAGE_AW'(g);
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) pbuf[g] <= `ERASED_WORD;
				else if (do_ldhi && ex_fa[PAGE_AW-1:0] == PI)
					pbuf[g][15:8] <= b4;
				else if (do_ldlo && ex_fa[PAGE_AW-1:0] == PI)
					pbuf[g][7:0] <= b4;
			end
		end
		for (g = 0; g < FLASH_WORDS; g++) begin : gen_flash
			localparam logic [FLASH_AW-1:0] WI = FLASH_AW'(g);
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) flash[g] <= `ERASED_WORD;
				else if (do_erase) flash[g] <= `ERASED_WORD;
				else if (do_page && ex_fa[FLASH_AW-1:PAGE_AW] ==
					WI[FLASH_AW-1:PAGE_AW])
					flash[g] <= pbuf[WI[PAGE_AW-1:0]];
			end
		end
		for (g = 0; g < EE_PAGE; g++) begin : gen_eebuf
			localparam logic [EE_PAGE_AW-1:0] QI = EE_PAGE_AW'(g);
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) begin
					eebuf[g] <= `ERASED_BYTE;
					ee_valid[g] <= 1'b0;
				end else if (do_eel && ex_ea[EE_PAGE_AW-1:0] == QI) begin
					eebuf[g] <= b4;
					ee_valid[g] <= 1'b1;
				end else if (do_eep || do_erase) begin
					ee_valid[g] <= 1'b0;
				end
			end
		end
		for (g = 0; g < EE_BYTES; g++) begin : gen_ee
			localparam logic [EE_AW-1:0] EI = EE_AW'(g);
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) eeprom[g] <= `ERASED_BYTE;
				else if (do_erase) eeprom[g] <= `ERASED_BYTE;
				else if (do_eew && ex_ea == EI) eeprom[g] <= b4;
				else if (do_eep && ee_valid[EI[EE_PAGE_AW-1:0]] &&
					ex_ea[EE_AW-1:EE_PAGE_AW] == EI[EE_AW-1:EE_PAGE_AW])
					eeprom[g] <= eebuf[EI[EE_PAGE_AW-1:0]];
			end
		end
	endgenerate

	// self-timed busy period after each write or erase
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt <= 32'h0;
			busy_flash <= 1'b0;
			busy_ee <= 1'b0;
			busy_page <= '0;
			busy_ee_addr <= '0;
			busy_ee_pg <= 1'b0;
		end else if (do_erase) begin
			busy_cnt <= 32'(ERASE_CYC);
			busy_flash <= 1'b0;
			busy_ee <= 1'b0;
		end else if (do_lock || do_flo || do_fhi || do_fext) begin
			busy_cnt <= 32'(FUSE_CYC);
			busy_flash <= 1'b0;
			busy_ee <= 1'b0;
		end else if (do_page) begin
			busy_cnt <= 32'(PAGE_CYC);
			busy_flash <= 1'b1;
			busy_ee <= 1'b0;
			busy_page <= ex_fa[FLASH_AW-1:PAGE_AW];
		end else if (do_eew || do_eep) begin
			busy_cnt <= 32'(EE_CYC);
			busy_flash <= 1'b0;
			busy_ee <= 1'b1;
			busy_ee_addr <= ex_ea;
			busy_ee_pg <= do_eep;
		end else if (busy_cnt != 32'h0) begin
			busy_cnt <= busy_cnt - 32'h1;
		end else begin
			busy_flash <= 1'b0;
			busy_ee <= 1'b0;
		end
	end

	// busy flag, also the poll answer
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) busy_o <= 1'b0;
		else busy_o <= (do_erase || do_lock || do_flo || do_fhi || do_fext ||
			do_page || do_eew || do_eep || busy_cnt > 32'h1);
	end
endmodule : isp_target

//--- core/isp_defs.svh
// constants for the four-byte serial programming link
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// first instruction byte
`define OP_CTRL 8'hac
`define OP_POLL 8'hf0
`define OP_EXT_ADDR 8'h4d
`define OP_LOAD_HI 8'h48
`define OP_LOAD_LO 8'h40
`define OP_PAGE_WR 8'h4c
`define OP_READ_HI 8'h28
`define OP_READ_LO 8'h20
`define OP_EE_READ 8'ha0
`define OP_READ_LOCK 8'h58
`define OP_READ_FUSE 8'h50
`define OP_SIG 8'h30
`define OP_CALIB 8'h38
`define OP_EE_WRITE 8'hc0
`define OP_EE_LOAD 8'hc1
`define OP_EE_PAGE 8'hc2

// second byte under the control opcode
`define SUB_PROG_EN 8'h53
`define SUB_ERASE 8'h80
`define SUB_LOCK 8'he0
`define SUB_FUSE_LO 8'ha0
`define SUB_FUSE_HI 8'ha8
`define SUB_FUSE_EXT 8'ha4
// second byte selecting the high fuse or extended fuse on reads
`define SUB_HI_SEL 8'h08

// erased contents and reset values
`define ERASED_BYTE 8'hff
`define ERASED_WORD 16'hffff
`define ZERO_BYTE 8'h00

// timing: clock rate and minimum wait delays
`define REF_CLK_MHZ 40.0
`define FUSE_WRITE_WAIT_MS 4.5
`define PAGE_WRITE_WAIT_MS 4.5
`define EEPROM_WRITE_WAIT_MS 9.0
`define ERASE_WAIT_MS 9.0
`define SCK_HALF_CYC 8

`endif

//--- core/isp_pkg.sv
// types shared by both ends of the serial programming link
package isp_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW = 2'b01,
		H_HIGH = 2'b11,
		H_WAIT = 2'b10
	} host_state_e;
endpackage : isp_pkg

//--- core/isp_link_if.sv
// wires of the serial programming link between programmer and target
`timescale 1ns/1ps
interface isp_link_if;
	logic sck;
	logic mosi;
	logic miso;
	logic prog_reset_n;
	modport programmer (output sck, output mosi, output prog_reset_n,
		input miso);
	modport target (input sck, input mosi, input prog_reset_n,
		output miso);
endinterface : isp_link_if

//--- core/isp_programmer.sv
// programmer end: command fifo and four-byte serial shifter with write waits
`timescale 1ns/1ps
`include "isp_defs.svh"

// command buffer with registered full and empty flags
module isp_cmd_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 32
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, rptr;
	logic [AW:0] cnt, next_cnt;
	logic push, pop;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rptr];
	assign next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);

	// storage write
	always_ff @(posedge ref_clk_i) begin
		if (push) mem[wptr] <= in_data_i;
	end

	// pointers, count and flags
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr <= '0;
			rptr <= '0;
			cnt <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (push) wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
			if (pop) rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
			cnt <= next_cnt;
			in_ready_o <= next_cnt != (AW + 1)'(DEPTH);
			out_valid_o <= next_cnt != '0;
		end
	end
endmodule : isp_cmd_fifo

module isp_programmer import isp_pkg::*; #(
	parameter int unsigned FIFO_DEPTH = 32,
	parameter int unsigned SCK_HALF = `SCK_HALF_CYC,
	parameter int unsigned FUSE_CYC =
		int'($ceil(`FUSE_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned PAGE_CYC =
		int'($ceil(`PAGE_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned EE_CYC =
		int'($ceil(`EEPROM_WRITE_WAIT_MS * `REF_CLK_MHZ * 1000.0)),
	parameter int unsigned ERASE_CYC =
		int'($ceil(`ERASE_WAIT_MS * `REF_CLK_MHZ * 1000.0))
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] cmd_data_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic release_i,
	output logic [31:0] resp_data_o,
	output logic resp_valid_o,
	output logic sync_ok_o,
	isp_link_if.programmer link
);
	host_state_e state;
	logic [31:0] fifo_data, tx, rx, cur;
	logic fifo_valid, fifo_pop;
	logic [1:0] miso_s;
	logic [4:0] bit_cnt;
	logic [15:0] half_cnt;
	logic [31:0] wait_cnt, wait_need;
	byte_t op, sub;

	// commands queue here; the shifter stalls the fifo while busy
	isp_cmd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_data_i(cmd_data_i),
		.in_valid_i(cmd_valid_i),
		.in_ready_o(cmd_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop)
	);
	assign fifo_pop = (state == H_IDLE) && fifo_valid && !link.prog_reset_n;

	// miso synchroniser
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) miso_s <= 2'b00;
		else miso_s <= {miso_s[0], link.miso};
	end

	// minimum wait after each write or erase, since no polling is done
	assign op = cur[31:24];
	assign sub = cur[23:16];
	always_comb begin
		wait_need = 32'(SCK_HALF);
		if (op == `OP_CTRL && sub == `SUB_ERASE) wait_need = 32'(ERASE_CYC);
		else if (op == `OP_CTRL && sub != `SUB_PROG_EN)
			wait_need = 32'(FUSE_CYC);
		else if (op == `OP_PAGE_WR) wait_need = 32'(PAGE_CYC);
		else if (op == `OP_EE_WRITE || op == `OP_EE_PAGE)
			wait_need = 32'(EE_CYC);
	end

	// reset line of the target: low holds it in programming mode
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) link.prog_reset_n <= 1'b0;
		else link.prog_reset_n <= release_i;
	end

	// shifter: mosi changes while sck is low, miso sampled at the rise
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= H_IDLE;
			tx <= 32'h0;
			cur <= 32'h0;
			rx <= 32'h0;
			bit_cnt <= 5'h00;
			half_cnt <= 16'h0;
			wait_cnt <= 32'h0;
			link.sck <= 1'b0;
			link.mosi <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_data_o <= 32'h0;
			sync_ok_o <= 1'b0;
		end else begin
			resp_valid_o <= 1'b0;
			case (state)
				H_IDLE: begin
					if (fifo_pop) begin
						tx <= fifo_data;
						cur <= fifo_data; // unshifted copy for decode at the end
						link.mosi <= fifo_data[31];
						bit_cnt <= 5'h00;
						half_cnt <= 16'(SCK_HALF);
						state <= H_LOW;
					end
				end
				H_LOW: begin
					if (half_cnt > 16'h1) begin
						half_cnt <= half_cnt - 16'h1;
					end else begin
						link.sck <= 1'b1;
						rx <= {rx[30:0], miso_s[1]};
						half_cnt <= 16'(SCK_HALF);
						state <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_cnt > 16'h1) begin
						half_cnt <= half_cnt - 16'h1;
					end else begin
						link.sck <= 1'b0;
						half_cnt <= 16'(SCK_HALF);
						if (bit_cnt == 5'd31) begin
							resp_valid_o <= 1'b1;
							resp_data_o <= rx;
							if (op == `OP_CTRL && sub == `SUB_PROG_EN)
								sync_ok_o <= rx[15:8] == `SUB_PROG_EN;
							wait_cnt <= wait_need;
							state <= H_WAIT;
						end else begin
							tx <= {tx[30:0], 1'b0};
							link.mosi <= tx[30];
							bit_cnt <= bit_cnt + 5'h01;
							state <= H_LOW;
						end
					end
				end
				H_WAIT: begin
					if (wait_cnt > 32'h1) wait_cnt <= wait_cnt - 32'h1;
					else state <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end
endmodule : isp_programmer

//--- bench/isp_chk.sv
// concurrent checks on the wires of the serial programming link
`timescale 1ns/1ps
module isp_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic prog_reset_n
);
	logic sck_q;
	logic [4:0] bit_cnt;
	logic [7:0] mosi_hist;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// previous link clock level for rise detection
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) sck_q <= 1'b0;
		else sck_q <= sck;
	end

	// bit position within the instruction, cleared while link is idle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) bit_cnt <= 5'h00;
		else if (prog_reset_n) bit_cnt <= 5'h00;
		else if (sck && !sck_q) bit_cnt <= bit_cnt + 5'h01;
	end

	// last eight bits taken from mosi, newest in bit 0
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) mosi_hist <= 8'h00;
		else if (sck && !sck_q) mosi_hist <= {mosi_hist[6:0], mosi};
	end

	a_mosi_on_fall: assert property ($changed(mosi) |-> !sck)
		else $error("mosi changed while link clock high");
	a_miso_on_fall: assert property ($changed(miso) |-> !sck)
		else $error("miso changed while link clock high");
	a_sck_high_len: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("link clock high phase has wrong length");
	a_sck_low_min: assert property ($fell(sck) |-> !sck[*8])
		else $error("link clock low phase too short");
	a_idle_no_clock: assert property (prog_reset_n |-> !sck)
		else $error("link clock runs outside programming mode");
	a_first_byte_zero: assert property (
		$rose(sck) && bit_cnt >= 5'd1 && bit_cnt < 5'd8 |-> !miso)
		else $error("first byte out is not zero");
	a_echo_prev_byte: assert property (
		$rose(sck) && bit_cnt >= 5'd8 && bit_cnt < 5'd24
		|-> miso == mosi_hist[7])
		else $error("miso does not echo the previous byte");
	a_frame_whole: assert property ($rose(prog_reset_n) |-> bit_cnt == 5'h00)
		else $error("link left programming mode mid instruction");
endmodule : isp_chk

//--- bench/testbench.sv
// self-checking bench: programmer and target joined over the link
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
	localparam int CYC = 200;
	// target eeprom time outlasts the programmer's wait so busy can be seen
	localparam int EE_SLOW = 2000;
	localparam int LIM = 40000;
	// signature and calibration values are arbitrary
	localparam logic [7:0] SIG [3] = '{8'h5a, 8'h6b, 8'h7c};
	localparam logic [7:0] CAL = 8'h6d;
	localparam logic [7:0] WSUB [4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
	localparam logic [15:0] RSEL [4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
	localparam logic [7:0] FVAL [4] = '{8'hfc, 8'he1, 8'h99, 8'hfd};
	logic ref_clk, rst, cmd_valid, cmd_ready, release_req, resp_valid;
	logic sync_ok, busy, prog_en;
	logic [31:0] cmd_data, resp_data, r;
	int fail_count = 0;
	int checked = 0;
	int n, k;

	isp_link_if link ();

	isp_programmer #(.FUSE_CYC(CYC), .PAGE_CYC(CYC), .EE_CYC(CYC),
		.ERASE_CYC(CYC)) u_isp_programmer (.ref_clk_i(ref_clk), .rst_i(rst),
		.cmd_data_i(cmd_data), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
		.release_i(release_req), .resp_data_o(resp_data),
		.resp_valid_o(resp_valid), .sync_ok_o(sync_ok), .link(link.programmer));

	isp_target #(.FUSE_CYC(CYC), .PAGE_CYC(CYC), .EE_CYC(EE_SLOW),
		.ERASE_CYC(CYC), .SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2]),
		.CALIB(CAL)) u_isp_target (.ref_clk_i(ref_clk), .rst_i(rst),
		.link(link.target), .busy_o(busy), .prog_enabled_o(prog_en));

	isp_chk u_isp_chk (.ref_clk_i(ref_clk), .rst_i(rst), .sck(link.sck),
		.mosi(link.mosi), .miso(link.miso), .prog_reset_n(link.prog_reset_n));

	// free running reference clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test

	// one bounded wait step; a spent bound ends the run
	task automatic step(inout int cnt);
		@(negedge ref_clk);
		cnt++;
		if (cnt > LIM) begin
			fail_count++;
			$display("FAIL wait expected done seen timeout");
			end_of_test;
		end
	endtask : step

	// push one instruction and collect the four bytes shifted back
	task automatic cmd(input logic [31:0] c, output logic [31:0] rv);
		int cnt;
		cnt = 0;
		@(negedge ref_clk);
		cmd_data = c;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) step(cnt);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		while (resp_valid !== 1'b1) step(cnt);
		rv = resp_data;
	endtask : cmd

	task automatic send(input logic [31:0] c);
		logic [31:0] rv;
		cmd(c, rv);
	endtask : send

	task automatic rd(input logic [31:0] c, input logic [7:0] e, input string nm);
		logic [31:0] rv;
		cmd(c, rv);
		`CHECK(nm, e, rv[7:0])
	endtask : rd

	task automatic wait_idle;
		int cnt;
		cnt = 0;
		while (busy !== 1'b0) step(cnt);
	endtask : wait_idle

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done

	// main sequence
	initial begin
		rst = 1'b1;
		cmd_data = 32'h0000_0000;
		cmd_valid = 1'b0;
		release_req = 1'b0;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		rd(32'h2000_0200, 8'hff, "read before enable");
		cmd(32'hac53_0000, r);
		`CHECK("enable echo", 32'h00ac_5300, r)
		`CHECK("sync ok", 1'b1, sync_ok)
		`CHECK("enabled", 1'b1, prog_en)
		rd(32'hf000_0000, 8'h00, "poll idle");
		done("enable");
		send(32'hc000_05a5);
		rd(32'ha000_0500, 8'hff, "eeprom busy read");
		rd(32'hf000_0000, 8'h01, "poll busy");
		wait_idle;
		rd(32'ha000_0500, 8'ha5, "eeprom read");
		send(32'hc100_013c);
		send(32'hc200_0000);
		rd(32'ha000_0100, 8'hff, "eeprom page busy");
		wait_idle;
		rd(32'ha000_0100, 8'h3c, "eeprom page read");
		done("eeprom");
		send(32'h4d00_0000);
		send(32'h4000_0234);
		send(32'h4800_0212);
		send(32'h4c00_0000);
		rd(32'h2000_0200, 8'h34, "flash low");
		rd(32'h2800_0200, 8'h12, "flash high");
		done("flash");
		for (int i = 0; i < 4; i++) begin
			send({8'hac, WSUB[i], 8'h00, FVAL[i]});
			rd({RSEL[i], 16'h0000}, FVAL[i], "fuse lock");
		end
		for (int i = 0; i < 4; i++) begin
			rd({16'h3000, 6'h00, i[1:0], 8'h00}, (i < 3) ? SIG[i] : 8'hff,
				"signature");
		end
		rd(32'h3800_0000, CAL, "calibration");
		done("fuses");
		send(32'hac80_0000);
		rd(32'h2000_0200, 8'hff, "erased flash");
		rd(32'ha000_0500, 8'hff, "erased eeprom");
		rd(32'h5800_0000, 8'hff, "erased lock");
		done("erase");
		@(negedge ref_clk);
		release_req = 1'b1;
		n = 0;
		while (prog_en !== 1'b0) step(n);
		`CHECK("enable cleared", 1'b0, prog_en)
		// fill the command buffer while the link is held idle
		n = 0;
		@(negedge ref_clk);
		while (cmd_ready === 1'b1 && n < 40) begin
			cmd_data = (n == 0) ? 32'hac53_0000 : 32'hf000_0000;
			cmd_valid = 1'b1;
			@(negedge ref_clk);
			n++;
		end
		cmd_valid = 1'b0;
		`CHECK("buffer depth", 32, n)
		release_req = 1'b0;
		n = 0;
		k = 0;
		while (k < 32) begin
			step(n);
			if (resp_valid === 1'b1) k++;
		end
		`CHECK("buffer ready", 1'b1, cmd_ready)
		`CHECK("resync", 1'b1, sync_ok)
		`CHECK("re enabled", 1'b1, prog_en)
		done("buffer");
		end_of_test;
	end
endmodule : testbench
